// >>> core/sar_pkg.sv
`default_nettype none
package sar_pkg;
    // ==================================================================
    // widths and timing
    localparam int unsigned RES_BITS       = 12;
    localparam int unsigned SHORT_BITS     = 8;
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned MIN_LOW_NS     = 25;
    localparam int unsigned MIN_LOW_CYC    =
        (MIN_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned THROUGHPUT_US  = 25;
    localparam int unsigned THROUGHPUT_CYC = THROUGHPUT_US * CLK_MHZ;
    localparam int unsigned CYC_PER_BIT    = 128;
    localparam int unsigned ACQ_CYC        = 1024;
    localparam int unsigned SETTLE_CYC     = 2;

    // ==================================================================
    // bus map
    localparam logic [11:0] CTRL_OFF   = 12'h000;
    localparam logic [11:0] STAT_OFF   = 12'h004;
    localparam logic [11:0] RES_OFF    = 12'h008;
    localparam logic [11:0] IRQ_OFF    = 12'h00c;
    localparam logic [11:0] MASK_OFF   = 12'h010;
    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CTRL_SHORT = 1;
    localparam int unsigned IRQ_DONE   = 0;
    localparam int unsigned IRQ_IGN    = 1;
    localparam logic [1:0]  MASK_RST   = 2'h0;

    typedef enum logic [1:0] {
        ST_ACQ    = 2'b00,
        ST_DECIDE = 2'b01,
        ST_LATCH  = 2'b11
    } conv_state_e;

    // analog switch settings: 1 = reference/input, 0 = ground
    typedef struct packed {
        logic                msb_cap_switch;
        logic [RES_BITS-2:0] lower_switches;
        logic                comparator_zero_switch;
        logic                sample_input;
    } cap_ctrl_s;

    typedef struct packed {
        logic                rd_conv_n;
        logic                chip_en;
        logic                chip_sel_n;
        logic                width_full;
        logic                byte_addr_short_cycle;
    } ctrl_pins_s;
endpackage : sar_pkg
`default_nettype wire

// >>> core/sar_start_detect.sv
`default_nettype none
// ======================================================================
// start edge detector with minimum low-time qualifier
module sar_start_detect #(
    parameter int unsigned MIN_LOW = sar_pkg::MIN_LOW_CYC
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic start_ok,
    input  wire logic busy,
    output logic      start_pulse
);
    typedef struct packed {
        logic [7:0] low_cnt;
    } st_s;
    st_s q, d;

    // count cycles the start condition has been held
    always_comb
    begin
        d = q;
        if (start_ok && q.low_cnt != 8'hff)
            d.low_cnt = q.low_cnt + 8'h01;
        else if (!start_ok)
            d.low_cnt = 8'h00;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            q <= '0;
        else
            q <= d;
    end

    // start fires once the low has lasted the minimum; busy blocks it
    assign start_pulse = start_ok && !busy && // R1 R4
        (q.low_cnt == 8'(MIN_LOW - 1));
endmodule // sar_start_detect
`default_nettype wire

// >>> core/sar_result_mux.sv
`default_nettype none
// ======================================================================
// output word formatting and three-state enables
module sar_result_mux (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [11:0] result,
    input  wire logic        read_en,
    input  wire logic        width_full,
    input  wire logic        byte_sel,
    output logic      [11:0] result_bits_o,
    output logic      [11:0] result_bits_oe_n
);
    typedef struct packed {
        logic [11:0] data;
        logic [11:0] oe_n;
    } st_s;
    st_s q, d;

    // 8-bit read: high byte on top lines, low nibble plus zeros
    always_comb
    begin
        d = q;
        d.oe_n = 12'hfff;
        d.data = result;
        if (read_en)
        begin
            if (width_full)
                d.oe_n = 12'h000; // R15
            else
            begin
                d.oe_n = 12'h00f; // R15
                if (byte_sel)
                    d.data = {result[3:0], 8'h00};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            q <= {12'h000, 12'hfff};
        else
            q <= d;
    end

    assign result_bits_o    = q.data;
    assign result_bits_oe_n = q.oe_n;
endmodule // sar_result_mux
`default_nettype wire

// >>> core/sar_adc_control.sv
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`default_nettype none
// Overview of operation
// R1 - falling convert edge holds input and starts; low must last 25ns
// R2 - busy stays high until the result is latched to outputs
// R3 - data pins are high impedance throughout a conversion
// R4 - start requests are ignored while busy is high
// R5 - acquisition resumes as soon as bit decisions finish
// R6 - conversion plus acquisition fits in 25us
// R7 - host picks 8 or 12 bits, starts, then reads whole or bytes
// R8 - stand-alone: select and byte lines low, enable and width high
// R9 - stand-alone outputs enabled only with convert line high, not busy
// R10 - outputs float on falling edge, return after conversion ends
// R11 - positive pulse reads previous result then starts a new one
// R12 - sampling: msb switch to input, others ground, zero switch closed
// R13 - each bit tried at reference then kept by comparator decision
// R14 - byte line latched at start; high gives 8 bits, low nibble zero
// R15 - width high drives twelve bits; low chooses byte by byte line
// R16 - cycles per bit chosen so the throughput limit is met
module sar_adc_control #(
    parameter int unsigned CYC_PER_BIT = sar_pkg::CYC_PER_BIT,
    parameter int unsigned ACQ_CYC     = sar_pkg::ACQ_CYC
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hsel,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire sar_pkg::ctrl_pins_s pins,
    input  wire logic                comparator_high,
    output sar_pkg::cap_ctrl_s       caps,
    output logic                     busy,
    output logic      [11:0]         result_bits_o,
    output logic      [11:0]         result_bits_oe_n,
    output logic                     irq
);
    // ==================================================================
    // state
    typedef struct packed {
        sar_pkg::conv_state_e st;
        logic [11:0]          sar;
        logic [11:0]          result;
        logic [3:0]           bit_idx;
        logic [15:0]          cnt;
        logic                 short_cyc;
        logic                 busy;
        logic                 acquiring;
        logic                 sw_start;
        logic                 sw_short;
        logic                 rd_conv_q;
        logic [1:0]           irq_stat;
        logic [1:0]           irq_mask;
        logic                 dph_valid;
        logic                 dph_write;
        logic [11:0]          dph_addr;
        logic [31:0]          rdata;
    } st_s;
    st_s q, d;

    logic pin_pulse;
    logic start_pulse;
    logic sel_ok;
    logic sw_req;
    logic pin_req;
    logic [3:0] last_bit;

    // chip selected; in stand-alone these are tied active
    assign sel_ok  = pins.chip_en && !pins.chip_sel_n; // R8
    assign pin_req = sel_ok && !pins.rd_conv_n;
    assign sw_req  = q.sw_start;
    // register start is one cycle wide, so it skips the low-time count
    assign start_pulse = pin_pulse || (sw_req && !q.busy); // R1 R4
    assign last_bit = q.short_cyc ? 4'(sar_pkg::RES_BITS -
        sar_pkg::SHORT_BITS) : 4'h0;

    sar_start_detect #(
        .MIN_LOW (sar_pkg::MIN_LOW_CYC)
    ) u_start (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .start_ok    (pin_req),
        .busy        (q.busy),
        .start_pulse (pin_pulse)
    );

    // ==================================================================
    // conversion sequencer, bus slave and interrupt status
    always_comb
    begin
        logic [1:0] irq_set;
        irq_set = 2'b00;
        d = q;
        d.rd_conv_q = pins.rd_conv_n;
        d.sw_start = 1'b0;
        case (q.st)
            sar_pkg::ST_ACQ:
            begin
                if (q.cnt != 16'h0000)
                    d.cnt = q.cnt - 16'h0001;
                else
                    d.acquiring = 1'b1;
                if (start_pulse) // R1 R4
                begin
                    d.st = sar_pkg::ST_DECIDE;
                    d.busy = 1'b1; // R2
                    d.acquiring = 1'b0;
                    // byte line latched only here
                    d.short_cyc = sw_req ? q.sw_short // R14
                        : pins.byte_addr_short_cycle;
                    d.bit_idx = 4'(sar_pkg::RES_BITS - 1);
                    d.sar = 12'h800; // R13
                    d.cnt = 16'(CYC_PER_BIT - 1); // R16
                end
            end
            sar_pkg::ST_DECIDE:
            begin
                if (q.cnt != 16'h0000)
                    d.cnt = q.cnt - 16'h0001;
                else
                begin
                    // keep or drop the trial bit, then try next
                    if (!comparator_high)
                        d.sar[q.bit_idx] = 1'b0; // R13
                    if (q.bit_idx == last_bit)
                    begin
                        d.st = sar_pkg::ST_LATCH;
                        d.acquiring = 1'b1; // R5
                        d.cnt = 16'(sar_pkg::SETTLE_CYC - 1);
                    end
                    else
                    begin
                        d.bit_idx = q.bit_idx - 4'h1;
                        d.sar[q.bit_idx - 4'h1] = 1'b1; // R13
                        d.cnt = 16'(CYC_PER_BIT - 1);
                    end
                end
            end
            sar_pkg::ST_LATCH:
            begin
                // latch first; busy drops one cycle later
                d.result = q.short_cyc ? {q.sar[11:4], 4'h0} // R14
                    : q.sar;
                if (q.cnt != 16'h0000)
                    d.cnt = q.cnt - 16'h0001;
                else
                begin
                    d.busy = 1'b0; // R2
                    d.st = sar_pkg::ST_ACQ;
                    irq_set[sar_pkg::IRQ_DONE] = 1'b1;
                    d.cnt = 16'(ACQ_CYC - 1); // R6
                end
            end
            default:
                d.st = sar_pkg::ST_ACQ;
        endcase

        // start attempt while busy is counted as ignored
        if (q.busy && ((q.rd_conv_q && !pins.rd_conv_n && sel_ok) ||
            sw_req))
            irq_set[sar_pkg::IRQ_IGN] = 1'b1; // R4

        // data phase: read data from a register, writes take effect
        d.dph_valid = 1'b0;
        if (q.dph_valid && q.dph_write)
        begin
            if (q.dph_addr == sar_pkg::CTRL_OFF)
            begin
                d.sw_start = hwdata[sar_pkg::CTRL_START];
                d.sw_short = hwdata[sar_pkg::CTRL_SHORT]; // R7
            end
            else if (q.dph_addr == sar_pkg::MASK_OFF)
                d.irq_mask = hwdata[1:0];
        end
        if (hsel && hready && htrans[1])
        begin
            d.dph_valid = 1'b1;
            d.dph_write = hwrite;
            d.dph_addr = haddr[11:0];
            d.rdata = 32'h0000_0000;
            if (haddr[11:0] == sar_pkg::CTRL_OFF)
                d.rdata = {30'h0, q.sw_short, 1'b0};
            else if (haddr[11:0] == sar_pkg::STAT_OFF)
                d.rdata = {29'h0, q.short_cyc, q.acquiring, q.busy};
            else if (haddr[11:0] == sar_pkg::RES_OFF)
                d.rdata = {20'h0, q.result};
            else if (haddr[11:0] == sar_pkg::IRQ_OFF)
            begin
                d.rdata = {30'h0, q.irq_stat};
                if (!hwrite)
                    d.irq_stat = 2'b00;
            end
            else if (haddr[11:0] == sar_pkg::MASK_OFF)
                d.rdata = {30'h0, q.irq_mask};
        end
        // clear on read; a same-cycle set still wins
        d.irq_stat = d.irq_stat | irq_set;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
            q.st <= sar_pkg::ST_ACQ;
            q.irq_mask <= sar_pkg::MASK_RST;
            q.rd_conv_q <= 1'b1;
        end
        else
            q <= d;
    end

    // ==================================================================
    // analog switches: track input outside decisions
    always_comb
    begin
        caps = '0;
        if (q.st == sar_pkg::ST_DECIDE)
        begin
            caps.msb_cap_switch = q.sar[11]; // R13
            caps.lower_switches = q.sar[10:0];
        end
        else
        begin
            caps.msb_cap_switch = 1'b1; // R12
            caps.comparator_zero_switch = 1'b1; // R12
            caps.sample_input = 1'b1; // R5 R12
        end
    end

    // ==================================================================
    // output buffers: read line high and not busy
    sar_result_mux u_mux (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .result           (q.result),
        .read_en          (sel_ok && pins.rd_conv_n && !q.busy &&
                           !start_pulse), // R3 R9 R10 R11
        .width_full       (pins.width_full),
        .byte_sel         (pins.byte_addr_short_cycle),
        .result_bits_o    (result_bits_o),
        .result_bits_oe_n (result_bits_oe_n)
    );

    assign busy      = q.busy;
    assign hrdata    = q.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(q.irq_stat & q.irq_mask);

    // ==================================================================
    // checks
    sequence start_seq;
        !q.busy ##1 q.busy;
    endsequence

    busy_holds_a: assert property (@(posedge hclk) disable iff (!hresetn)
        start_seq |-> q.busy [*8]) // R2
        else $error("busy dropped early");
    outputs_float_a: assert property (@(posedge hclk)
        disable iff (!hresetn) q.busy |=> result_bits_oe_n == 12'hfff) // R3
        else $error("outputs driven while busy");
    no_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
        q.busy && q.st == sar_pkg::ST_DECIDE |=> $stable(q.short_cyc)) // R4
        else $error("conversion restarted");
    acq_early_a: assert property (@(posedge hclk) disable iff (!hresetn)
        q.st == sar_pkg::ST_LATCH |-> q.busy && caps.sample_input) // R5
        else $error("acquire not before busy fall");
    start_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        start_pulse |=> q.busy && !caps.comparator_zero_switch) // R1
        else $error("start did not hold input");
    short_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(q.busy) && q.short_cyc |-> q.result[3:0] == 4'h0) // R14
        else $error("short result low nibble set");
    read_en_a: assert property (@(posedge hclk) disable iff (!hresetn)
        result_bits_oe_n != 12'hfff |-> $past(pins.rd_conv_n)) // R9
        else $error("outputs driven with line low");
    sample_sw_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !q.busy |-> caps.msb_cap_switch && caps.lower_switches == 11'h0) // R12
        else $error("sampling switches wrong");
    float_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
        start_pulse |=> ##1 result_bits_oe_n == 12'hfff) // R10 R11
        else $error("outputs not floated at start");
endmodule // sar_adc_control
`default_nettype wire

// >>> bench/sar_front_model.sv
`default_nettype none
// ======================================================================
// analog front end: comparator answer for the trial word on the array
module sar_front_model (
    input  wire logic               hclk,
    input  wire sar_pkg::cap_ctrl_s caps,
    input  wire logic [11:0]        analog_code,
    output logic                    comparator_high
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [11:0] trial;
    logic        tick_q = 1'b0;

    // weight of the switches now tied to the reference
    assign trial = {caps.msb_cap_switch, caps.lower_switches};

    // meaningless while sampling: flips so nothing leans on it
    always_ff @(posedge hclk)
        tick_q <= ~tick_q;

    // keeps a trial bit while the input is not below it
    assign comparator_high = caps.sample_input ? tick_q
                           : (trial <= analog_code);
endmodule // sar_front_model
`default_nettype wire

// >>> bench/sar_adc_standalone_control_bench.sv
`default_nettype none
// ======================================================================
// stand-alone pin and register bus checks of the converter control
module sar_adc_standalone_control_bench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int CPB = 4;
    localparam int ACQ = 8;

    typedef struct packed {
        logic [11:0] code;
        logic        sa;
        logic        wf;
        logic        rs;
        logic [11:0] exp;
        logic [11:0] oe;
    } row_s;

    logic                hclk;
    logic                hresetn;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic                hsel;
    logic                hready;
    logic [31:0]         hwdata;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    sar_pkg::ctrl_pins_s pins;
    logic                comparator_high;
    sar_pkg::cap_ctrl_s  caps;
    logic                busy;
    logic [11:0]         result_bits_o;
    logic [11:0]         result_bits_oe_n;
    logic                irq;
    logic [11:0]         code;
    logic [31:0]         r;
    int                  mismatches = 0;
    int                  compares = 0;
    int                  cyc = 0;
    int                  blen;
    int                  len12;
    int                  n;

    // code, start width, read width, read byte, word, enables
    row_s rows [5] = '{
        '{12'ha5c, 1'b0, 1'b1, 1'b0, 12'ha5c, 12'h000},
        '{12'h3c7, 1'b1, 1'b1, 1'b0, 12'h3c0, 12'h000},
        '{12'hfff, 1'b0, 1'b0, 1'b0, 12'hff0, 12'h00f},
        '{12'h9e1, 1'b0, 1'b0, 1'b1, 12'h100, 12'h00f},
        '{12'h000, 1'b1, 1'b0, 1'b1, 12'h000, 12'h00f}
    };

    assign hready = hreadyout;

    sar_adc_control #(
        .CYC_PER_BIT (CPB),
        .ACQ_CYC     (ACQ)
    ) u_sar_adc_control (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .haddr            (haddr),
        .htrans           (htrans),
        .hwrite           (hwrite),
        .hsize            (hsize),
        .hsel             (hsel),
        .hready           (hready),
        .hwdata           (hwdata),
        .hrdata           (hrdata),
        .hreadyout        (hreadyout),
        .hresp            (hresp),
        .pins             (pins),
        .comparator_high  (comparator_high),
        .caps             (caps),
        .busy             (busy),
        .result_bits_o    (result_bits_o),
        .result_bits_oe_n (result_bits_oe_n),
        .irq              (irq)
    );

    sar_front_model u_sar_front_model (
        .hclk            (hclk),
        .caps            (caps),
        .analog_code     (code),
        .comparator_high (comparator_high)
    );

    // ==================================================================
    // clock, timeout and report
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // whole run needs about six hundred cycles
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // ==================================================================
    // bus single word transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [31:0] a, d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
        chk(hresp, 1'b0);
    endtask

    // pin conversion; mode 1 pulses again while busy, 2 keeps line low
    task automatic conv(input logic sa, rs, wf, input int mode);
        logic hz_bad;
        hz_bad = 1'b0;
        n = 0;
        blen = 0;
        pins.byte_addr_short_cycle <= sa;
        pins.width_full <= wf;
        pins.rd_conv_n <= 1'b0;
        repeat (5) @(posedge hclk);
        chk(result_bits_oe_n, 12'hfff);
        if (mode != 2)
            pins.rd_conv_n <= 1'b1;
        while (busy !== 1'b1 && n < 20)
        begin
            @(posedge hclk);
            n++;
        end
        chk(busy, 1'b1);
        pins.byte_addr_short_cycle <= rs;
        while (busy === 1'b1 && blen < 400)
        begin
            if (result_bits_oe_n !== 12'hfff)
                hz_bad = 1'b1;
            if (mode == 1 && blen == 10)
                pins.rd_conv_n <= 1'b0;
            if (mode == 1 && blen == 16)
                pins.rd_conv_n <= 1'b1;
            @(posedge hclk);
            blen++;
        end
        chk(hz_bad, 1'b0);
        chk(caps.sample_input, 1'b1);
    endtask

    // ==================================================================
    // main sequence
    initial
    begin
        hresetn = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hsel = 1'b1;
        hwdata = 32'h0;
        code = 12'h000;
        pins = '{rd_conv_n: 1'b1, chip_en: 1'b1, chip_sel_n: 1'b0,
                 width_full: 1'b1, byte_addr_short_cycle: 1'b0};
        repeat (4) @(posedge hclk);
        chk({busy, irq, result_bits_oe_n}, {2'b00, 12'hfff});
        chk(caps, {1'b1, 11'h000, 1'b1, 1'b1});
        hresetn <= 1'b1;
        bus(1'b0, 32'h10, 32'h0);
        chk(r, 32'h0);

        // table of ordinary stand-alone conversions and reads
        foreach (rows[i])
        begin
            code <= rows[i].code;
            conv(rows[i].sa, rows[i].rs, rows[i].wf, 0);
            if (i == 0)
                len12 = blen;
            repeat (2) @(posedge hclk);
            chk(result_bits_oe_n, rows[i].oe);
            chk(result_bits_o & ~rows[i].oe, rows[i].exp);
            repeat (ACQ + 4) @(posedge hclk);
        end
        chk(len12 >= 12 * CPB && len12 <= 12 * CPB + 4, 1'b1);
        chk(irq, 1'b0);
        bus(1'b0, 32'h0c, 32'h0);
        chk(r, 32'h1);
        bus(1'b0, 32'h0c, 32'h0);
        chk(r, 32'h0);

        // second pulse while busy neither restarts nor shortens
        code <= 12'h5a5;
        conv(1'b0, 1'b0, 1'b1, 1);
        chk(blen, len12);
        repeat (2) @(posedge hclk);
        chk(result_bits_o, 12'h5a5);
        repeat (ACQ + 4) @(posedge hclk);

        // line held low: floating until it rises, then the new result shows
        code <= 12'h123;
        conv(1'b0, 1'b0, 1'b1, 2);
        repeat (2) @(posedge hclk);
        chk(result_bits_oe_n, 12'hfff);
        pins.rd_conv_n <= 1'b1;
        repeat (ACQ + 4) @(posedge hclk);
        chk({result_bits_oe_n, result_bits_o}, {12'h000, 12'h123});
        code <= 12'h456;
        conv(1'b0, 1'b0, 1'b1, 0);
        repeat (2) @(posedge hclk);
        chk(result_bits_o, 12'h456);
        bus(1'b0, 32'h0c, 32'h0);
        chk(r, 32'h3);

        // host control over the register bus with done unmasked
        bus(1'b1, 32'h10, 32'h1);
        bus(1'b0, 32'h10, 32'h0);
        chk(r, 32'h1);
        code <= 12'h7ab;
        bus(1'b1, 32'h00, 32'h3);
        bus(1'b1, 32'h00, 32'h1);
        bus(1'b0, 32'h04, 32'h0);
        chk(r & 32'h1, 32'h1);
        n = 0;
        while (busy !== 1'b0 && n < 400)
        begin
            @(posedge hclk);
            n++;
        end
        @(posedge hclk);
        chk(irq, 1'b1);
        bus(1'b0, 32'h08, 32'h0);
        chk(r, 32'h7a0);
        bus(1'b0, 32'h0c, 32'h0);
        chk(r, 32'h3);
        @(posedge hclk);
        chk(irq, 1'b0);
        bus(1'b1, 32'h20, 32'hffffffff);
        bus(1'b0, 32'h20, 32'h0);
        chk(r, 32'h0);

        // reset in mid-conversion: idle, floating, mask back to zero
        pins.rd_conv_n <= 1'b0;
        repeat (10) @(posedge hclk);
        chk(busy, 1'b1);
        hresetn <= 1'b0;
        pins.rd_conv_n <= 1'b1;
        @(posedge hclk);
        chk({busy, irq, result_bits_oe_n}, {2'b00, 12'hfff});
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({result_bits_oe_n, result_bits_o}, 24'h000000);
        bus(1'b0, 32'h10, 32'h0);
        chk(r, 32'h0);
        close_out();
    end
endmodule // sar_adc_standalone_control_bench
`default_nettype wire
